// [design/seewr_map.svh]
`ifndef SEEWR_MAP_SVH
`define SEEWR_MAP_SVH

// Slave address: upper nibble fixed, next three bits don't-care, LSB is direction
`define SEEWR_DEV_PATTERN      4'hA
`define SEEWR_DIR_READ         1'b1

// Array geometry
`define SEEWR_ADDR_W           14
`define SEEWR_PAGE_W           6
`define SEEWR_ROW_W            8
`define SEEWR_BYTE_W           8
`define SEEWR_BITS_PER_BYTE    4'h8

// Write-phase byte positions after START
`define SEEWR_PH_DEV           2'h0
`define SEEWR_PH_ADDR_HI       2'h1
`define SEEWR_PH_ADDR_LO       2'h2
`define SEEWR_PH_DATA          2'h3

// Timing
`define SEEWR_CLK_MHZ          200
`define SEEWR_PROG_TIME_MS     10
`define SEEWR_PROG_CYCLES      (`SEEWR_PROG_TIME_MS * `SEEWR_CLK_MHZ * 1000)

// Pin synchroniser depth
`define SEEWR_SYNC_STAGES      3

`endif

// [design/seewr_pkg.sv]
`include "seewr_map.svh"

package seewr_pkg;

    typedef enum logic [2:0] {
        SEEWR_ST_IDLE   = 3'h0,
        SEEWR_ST_DEVADR = 3'h1,
        SEEWR_ST_RX     = 3'h3,
        SEEWR_ST_ACK    = 3'h2,
        SEEWR_ST_TX     = 3'h6,
        SEEWR_ST_MACK   = 3'h7,
        SEEWR_ST_HOLD   = 3'h5,
        SEEWR_ST_PROG   = 3'h4
    } seewr_state_type;

    typedef struct packed {
        logic [`SEEWR_ADDR_W-1:0] addr;
        logic [`SEEWR_BYTE_W-1:0] data;
    } seewr_pgm_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } seewr_pins_type;

endpackage

// [design/seewr_buf.sv]
`timescale 1ns/10ps

module seewr_buf #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wptr_ff;
    logic [PW-1:0]    rptr_ff;
    logic [CW-1:0]    count_ff;
    wire              push;
    wire              pop;
    wire  [PW-1:0]    wptr_inc;
    wire  [PW-1:0]    rptr_inc;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign wptr_inc  = (wptr_ff == PW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
    assign rptr_inc  = (rptr_ff == PW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= wptr_inc;
            end
            if (pop) begin
                rptr_ff <= rptr_inc;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule // seewr_buf

// [design/seewr_slave.sv]
// Summary of operation
// - During programming the bus is ignored, data line released, address not acknowledged.
// - Programming starts at STOP ending a write and lasts until finished.
// - Every bit in or out is timed by the bus clock alone.
// - Data line is only pulled low or released, never driven high.
// - Protect input high blocks all array writes; low allows them.
// - Data changes only while clock low; changes with clock high are START/STOP.
// - START is data falling with clock high; silent until one is seen.
// - STOP is data rising with clock high; every operation ends with STOP.
// - Address byte upper nibble is 1010; next three bits are don't-care.
// - Last address bit selects read when 1, write when 0.
// - Acknowledge only on address match, then perform the selected direction.
// - Receiver pulls data low during the ninth clock of each byte.
// - When selected for write and not protected, acknowledge every received byte.
// - Read: send 8 bits, release, sample ack; continue on ack else await STOP.
// - A page write carries up to 64 data bytes in one program cycle.
// - Each written byte increments only the six low address bits.
// - Beyond 64 bytes the in-page address wraps and overwrites earlier bytes.
// - STOP commits all buffered page bytes in one program cycle.
// - Address polls are not acknowledged while programming, acknowledged afterward.
// - Protected: acknowledge addresses, refuse first data byte, program nothing.
// - Address counter holds last address plus one, wrapping 16383 to 0 on reads and within the page on writes.
`timescale 1ns/10ps
`include "seewr_map.svh"

module seewr_slave #(
    parameter int unsigned PROG_CYCLES = `SEEWR_PROG_CYCLES,
    parameter int          BUF_DEPTH   = 2
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    input  wire logic                          wp_in,
    output logic         [`SEEWR_ADDR_W-1:0]   mem_rd_addr,
    input  wire logic    [`SEEWR_BYTE_W-1:0]   mem_rd_data,
    output logic                               pgm_valid,
    input  wire logic                          pgm_ready,
    output seewr_pkg::seewr_pgm_type           pgm_word,
    output logic                               busy
);
    import seewr_pkg::*;

    localparam int PAGE_N = 1 << `SEEWR_PAGE_W;
    localparam int TW     = $clog2(PROG_CYCLES + 1);

    // Pin synchronisers: three stages, a change is accepted once stages two and three agree
    seewr_pins_type                      pins_raw;
    logic [`SEEWR_SYNC_STAGES-1:0]       sync_ff [3];
    logic [2:0]                          flt_ff;
    logic [2:0]                          prev_ff;

    assign pins_raw = '{scl: scl_in, sda: sda_in, wp: wp_in};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync_ff[i] <= '1;
                    flt_ff[i]  <= 1'b1;
                    prev_ff[i] <= 1'b1;
                end else begin
                    sync_ff[i] <= {sync_ff[i][1:0], pins_raw[i]};
                    if (sync_ff[i][1] == sync_ff[i][2]) begin
                        flt_ff[i] <= sync_ff[i][2];
                    end
                    prev_ff[i] <= flt_ff[i];
                end
            end
        end
    endgenerate

    // Bit positions in the packed pin struct: scl=2, sda=1, wp=0
    wire scl       = flt_ff[2];
    wire sda       = flt_ff[1];
    wire wp        = flt_ff[0];
    wire scl_rise  = scl & ~prev_ff[2];
    wire scl_fall  = ~scl & prev_ff[2];
    wire start_det = scl & prev_ff[2] & prev_ff[1] & ~sda;
    wire stop_det  = scl & prev_ff[2] & ~prev_ff[1] & sda;

    seewr_state_type                    state_ff, nxt_state;
    logic [3:0]                         bit_cnt_ff, nxt_bit_cnt;
    logic [7:0]                         shift_ff, nxt_shift;
    logic [1:0]                         phase_ff, nxt_phase;
    logic                               rw_ff, nxt_rw;
    logic                               mack_ff, nxt_mack;
    logic                               oe_ff, nxt_oe;
    logic                               pend_ff, nxt_pend;
    logic [`SEEWR_ADDR_W-1:0]           addr_ff, nxt_addr;
    logic [`SEEWR_PAGE_W-1:0]           hi_ff, nxt_hi;
    logic [`SEEWR_ROW_W-1:0]            row_ff;
    logic [`SEEWR_BYTE_W-1:0]           page_ff [PAGE_N];
    logic [PAGE_N-1:0]                  mask_ff;
    logic [`SEEWR_PAGE_W:0]             cidx_ff;
    logic [TW-1:0]                      timer_ff;
    logic                               data_take;
    logic                               go_prog;
    logic                               mask_clr;

    wire dev_match  = (shift_ff[7:4] == `SEEWR_DEV_PATTERN);
    wire byte_done  = scl_fall & (bit_cnt_ff == `SEEWR_BITS_PER_BYTE);
    wire in_prog    = (state_ff == SEEWR_ST_PROG);
    wire timer_done = (timer_ff == TW'(PROG_CYCLES - 1));
    wire commit_done = cidx_ff[`SEEWR_PAGE_W];
    wire [`SEEWR_PAGE_W-1:0] cur_idx = cidx_ff[`SEEWR_PAGE_W-1:0];
    wire buf_in_ready;
    wire buf_in_valid = in_prog & ~commit_done & mask_ff[cur_idx];
    wire commit_step  = in_prog & ~commit_done & (~mask_ff[cur_idx] | buf_in_ready);
    wire prog_exit    = in_prog & commit_done & timer_done;
    wire [`SEEWR_ADDR_W-1:0] addr_inc = addr_ff + 1'b1;
    wire [`SEEWR_PAGE_W-1:0] page_inc = addr_ff[`SEEWR_PAGE_W-1:0] + 1'b1;

    seewr_pgm_type buf_in_word;
    assign buf_in_word = '{addr: {row_ff, cur_idx}, data: page_ff[cur_idx]};

    always_comb begin
        nxt_state   = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift   = shift_ff;
        nxt_phase   = phase_ff;
        nxt_rw      = rw_ff;
        nxt_mack    = mack_ff;
        nxt_oe      = oe_ff;
        nxt_pend    = pend_ff;
        nxt_addr    = addr_ff;
        nxt_hi      = hi_ff;
        data_take   = 1'b0;
        go_prog     = 1'b0;
        mask_clr    = 1'b0;
        if (in_prog) begin
            nxt_oe = 1'b0;
            if (prog_exit) begin
                nxt_state = SEEWR_ST_IDLE;
                nxt_pend  = 1'b0;
                mask_clr  = 1'b1;
            end
        end else if (start_det) begin
            nxt_state   = SEEWR_ST_DEVADR;
            nxt_bit_cnt = '0;
            nxt_phase   = `SEEWR_PH_DEV;
            nxt_oe      = 1'b0;
        end else if (stop_det) begin
            nxt_oe = 1'b0;
            if (pend_ff && !wp) begin
                go_prog   = 1'b1;
                nxt_state = SEEWR_ST_PROG;
            end else begin
                nxt_state = SEEWR_ST_IDLE;
                nxt_pend  = 1'b0;
                mask_clr  = 1'b1;
            end
        end else begin
            unique case (state_ff)
                SEEWR_ST_IDLE, SEEWR_ST_HOLD: begin
                end
                SEEWR_ST_DEVADR, SEEWR_ST_RX: begin
                    if (scl_rise && bit_cnt_ff != `SEEWR_BITS_PER_BYTE) begin
                        nxt_shift   = {shift_ff[6:0], sda};
                        nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    end else if (byte_done) begin
                        nxt_state = SEEWR_ST_ACK;
                        nxt_oe    = 1'b1;
                        if (state_ff == SEEWR_ST_DEVADR) begin
                            nxt_rw    = shift_ff[0];
                            nxt_phase = `SEEWR_PH_ADDR_HI;
                            if (!dev_match) begin
                                nxt_state = SEEWR_ST_HOLD;
                                nxt_oe    = 1'b0;
                            end
                        end else if (phase_ff == `SEEWR_PH_ADDR_HI) begin
                            nxt_hi    = shift_ff[`SEEWR_PAGE_W-1:0];
                            nxt_phase = `SEEWR_PH_ADDR_LO;
                        end else if (phase_ff == `SEEWR_PH_ADDR_LO) begin
                            nxt_addr  = {hi_ff, shift_ff};
                            nxt_phase = `SEEWR_PH_DATA;
                        end else if (wp) begin
                            nxt_state = SEEWR_ST_HOLD;
                            nxt_oe    = 1'b0;
                        end else begin
                            data_take = 1'b1;
                            nxt_pend  = 1'b1;
                            nxt_addr  = {addr_ff[`SEEWR_ADDR_W-1:`SEEWR_PAGE_W],
                                         page_inc};
                        end
                    end
                end
                SEEWR_ST_ACK: begin
                    if (scl_fall) begin
                        nxt_bit_cnt = '0;
                        nxt_oe      = 1'b0;
                        nxt_state   = SEEWR_ST_RX;
                        if (rw_ff == `SEEWR_DIR_READ) begin
                            nxt_state   = SEEWR_ST_TX;
                            nxt_shift   = mem_rd_data;
                            nxt_oe      = ~mem_rd_data[7];
                            nxt_bit_cnt = 4'h1;
                            nxt_addr    = addr_inc;
                        end
                    end
                end
                SEEWR_ST_TX: begin
                    if (byte_done) begin
                        nxt_oe    = 1'b0;
                        nxt_state = SEEWR_ST_MACK;
                    end else if (scl_fall) begin
                        nxt_shift   = {shift_ff[6:0], 1'b0};
                        nxt_oe      = ~shift_ff[6];
                        nxt_bit_cnt = bit_cnt_ff + 1'b1;
                    end
                end
                SEEWR_ST_MACK: begin
                    if (scl_rise) begin
                        nxt_mack = ~sda;
                    end else if (scl_fall) begin
                        if (mack_ff) begin
                            nxt_state   = SEEWR_ST_TX;
                            nxt_shift   = mem_rd_data;
                            nxt_oe      = ~mem_rd_data[7];
                            nxt_bit_cnt = 4'h1;
                            nxt_addr    = addr_inc;
                        end else begin
                            nxt_state = SEEWR_ST_HOLD;
                        end
                    end
                end
                SEEWR_ST_PROG: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= SEEWR_ST_IDLE;
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
            phase_ff   <= `SEEWR_PH_DEV;
            rw_ff      <= 1'b0;
            mack_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            pend_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff   <= nxt_shift;
            phase_ff   <= nxt_phase;
            rw_ff      <= nxt_rw;
            mack_ff    <= nxt_mack;
            oe_ff      <= nxt_oe;
            pend_ff    <= nxt_pend;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_ff <= '0;
            hi_ff   <= '0;
            row_ff  <= '0;
        end else begin
            addr_ff <= nxt_addr;
            hi_ff   <= nxt_hi;
            if (go_prog) begin
                row_ff <= addr_ff[`SEEWR_ADDR_W-1:`SEEWR_PAGE_W];
            end
        end
    end

    // Page buffer: one entry per in-page offset, mask marks bytes to commit
    generate
        for (genvar p = 0; p < PAGE_N; p++) begin : g_page
            wire hit = data_take & (addr_ff[`SEEWR_PAGE_W-1:0] == `SEEWR_PAGE_W'(p));
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    page_ff[p] <= '0;
                    mask_ff[p] <= 1'b0;
                end else begin
                    if (hit) begin
                        page_ff[p] <= shift_ff;
                    end
                    if (hit) begin
                        mask_ff[p] <= 1'b1;
                    end else if (mask_clr) begin
                        mask_ff[p] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Program cycle: stream marked bytes out and run the cycle timer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cidx_ff  <= '0;
            timer_ff <= '0;
        end else if (go_prog) begin
            cidx_ff  <= '0;
            timer_ff <= '0;
        end else if (in_prog) begin
            if (commit_step) begin
                cidx_ff <= cidx_ff + 1'b1;
            end
            if (!timer_done) begin
                timer_ff <= timer_ff + 1'b1;
            end
        end
    end

    seewr_buf #(
        .WIDTH ($bits(seewr_pgm_type)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_word),
        .out_valid (pgm_valid),
        .out_ready (pgm_ready),
        .out_data  (pgm_word)
    );

    assign sda_out     = 1'b0;
    assign sda_oe      = oe_ff;
    assign mem_rd_addr = addr_ff;
    assign busy        = in_prog;

endmodule // seewr_slave

// [verification/seewr_slave_chk.sv]
`timescale 1ns/10ps
`include "seewr_map.svh"
module seewr_slave_chk
    import seewr_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 2000
) (
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      scl_in,
    input wire logic                      sda_in,
    input wire logic                      sda_out,
    input wire logic                      sda_oe,
    input wire logic                      wp_in,
    input wire logic [`SEEWR_ADDR_W-1:0]  mem_rd_addr,
    input wire logic [`SEEWR_BYTE_W-1:0]  mem_rd_data,
    input wire logic                      pgm_valid,
    input wire logic                      pgm_ready,
    input wire seewr_pkg::seewr_pgm_type  pgm_word,
    input wire logic                      busy
);
    logic [4:0]    low_ff;
    logic          sda_ff;
    logic          busy_ff;
    logic          started_ff;
    logic          have_ff;
    seewr_pgm_type last_ff;
    int unsigned   len_ff;
    logic [3:0]    wph_ff;
    logic          take;
    assign take = pgm_valid && pgm_ready;
    // Clock-low age, raw START seen, last program word of this cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_ff     <= 5'h00;
            sda_ff     <= 1'b1;
            busy_ff    <= 1'b0;
            started_ff <= 1'b0;
            have_ff    <= 1'b0;
            len_ff     <= 0;
            wph_ff     <= 4'h0;
            last_ff    <= '0;
        end else begin
            low_ff     <= scl_in ? 5'h00 : low_ff + 5'(low_ff != 5'h1F);
            sda_ff     <= sda_in;
            busy_ff    <= busy;
            started_ff <= started_ff | (scl_in & sda_ff & ~sda_in);
            have_ff    <= take | (have_ff & ~(busy & ~busy_ff));
            len_ff     <= busy ? len_ff + 1 : 0;
            wph_ff     <= wp_in ? wph_ff + 4'(wph_ff != 4'hF) : 4'h0;
            if (take) last_ff <= pgm_word;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_next; take && have_ff; endsequence
    sequence s_stall; pgm_valid && !pgm_ready; endsequence
    property p_open_drain; sda_oe |-> sda_out == 1'b0; endproperty
    property p_busy_quiet; busy |-> !sda_oe; endproperty
    property p_bus_timed; $changed(sda_oe) |-> !scl_in && low_ff inside {[3:12]}; endproperty
    property p_silent; !started_ff |-> !sda_oe; endproperty
    property p_ack_width; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    property p_pgm_order;
        s_next |-> pgm_word.addr[13:6] == last_ff.addr[13:6]
                   && pgm_word.addr[5:0] > last_ff.addr[5:0];
    endproperty
    property p_pgm_hold; s_stall |=> pgm_valid && $stable(pgm_word); endproperty
    property p_pgm_in_busy; $rose(pgm_valid) |-> busy; endproperty
    property p_prog_len; $fell(busy) |-> len_ff >= PROG_CYCLES - 2; endproperty
    // Protect pin settled high before the STOP must keep the cycle from starting
    property p_protect; $rose(busy) |-> wph_ff < 4'h8; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    a_busy_quiet: assert property (p_busy_quiet) else $error("line pulled while busy");
    a_bus_timed: assert property (p_bus_timed) else $error("line change not after clock fall");
    a_silent: assert property (p_silent) else $error("line pulled before any start");
    a_ack_width: assert property (p_ack_width) else $error("pulled low too briefly");
    a_pgm_order: assert property (p_pgm_order) else $error("program words out of order");
    a_pgm_hold: assert property (p_pgm_hold) else $error("program word dropped");
    a_pgm_in_busy: assert property (p_pgm_in_busy) else $error("program word outside cycle");
    a_prog_len: assert property (p_prog_len) else $error("program cycle too short");
    a_protect: assert property (p_protect) else $error("protected write programmed");
endmodule // seewr_slave_chk

// [verification/seewr_master.sv]
`timescale 1ns/10ps
module seewr_master (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda_bus
);
    // Both lines released while idle; clock stands high between frames
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    task automatic start();
        sda_m = 1'b1;
        #60 scl = 1'b1;
        #80 sda_m = 1'b0;
        #80 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda_m = 1'b0;
        #60 scl = 1'b1;
        #80 sda_m = 1'b1;
        #80;
    endtask
    // Data moves only with the clock low
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_m = b[i];
            #60 scl = 1'b1;
            #80 scl = 1'b0;
        end
        #20 sda_m = 1'b1;
        #60 scl = 1'b1;
        #40 ack = ~sda_bus;
        #40 scl = 1'b0;
    endtask
    task automatic recv(input logic mack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #80 scl = 1'b1;
            #40 b[i] = sda_bus;
            #40 scl = 1'b0;
        end
        #20 sda_m = ~mack;
        #60 scl = 1'b1;
        #80 scl = 1'b0;
        #20 sda_m = 1'b1;
    endtask
endmodule // seewr_master

// [verification/seewr_slave_test.sv]
`timescale 1ns/10ps
module seewr_slave_test;
    import seewr_pkg::*;
    localparam int unsigned PROG = 2000;
    typedef struct packed {
        logic [7:0]  dev;
        logic [15:0] addr;
        logic        wp;
        logic [7:0]  count;
        logic        data_ack;
    } seewr_row_type;
    logic          clk, resetn, scl, sda_m, sda_bus, sda_out, sda_oe;
    logic          wp_in, pgm_valid, pgm_ready, busy, ack;
    logic [13:0]   mem_rd_addr;
    logic [7:0]    mem_rd_data, rd;
    seewr_pgm_type pgm_word;
    logic [7:0]    mem [0:16383];
    logic [7:0]    exp_mem [0:16383];
    int            err_total, comparisons;
    seewr_row_type rows [4] = '{'{8'hA0, 16'h0000, 1'b0, 8'h01, 1'b1},
        '{8'hAE, 16'hFFFF, 1'b0, 8'h01, 1'b1}, '{8'hA6, 16'h1234, 1'b1, 8'h02, 1'b0},
        '{8'hA2, 16'h1230, 1'b0, 8'h04, 1'b1}};
    seewr_slave #(.PROG_CYCLES(PROG)) i_dut (.clk(clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in),
        .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .pgm_valid(pgm_valid),
        .pgm_ready(pgm_ready), .pgm_word(pgm_word), .busy(busy));
    seewr_master i_mst (.scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));
    // Wired-AND with pull-up
    assign sda_bus = sda_m & ~(sda_oe & ~sda_out);
    assign mem_rd_data = mem[mem_rd_addr];
    always #2.5 clk = ~clk;
    always @(posedge clk) if (pgm_valid && pgm_ready) mem[pgm_word.addr] <= pgm_word.data;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while ((busy !== 1'b0 || pgm_valid !== 1'b0) && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check(16'(n < 20000), 16'h0001);
    endtask
    task automatic address(input logic [7:0] dev, input logic [15:0] a);
        i_mst.start();
        i_mst.send(dev & 8'hFE, ack);
        check(16'(ack), 16'h0001);
        i_mst.send(a[15:8], ack);
        check(16'(ack), 16'h0001);
        i_mst.send(a[7:0], ack);
        check(16'(ack), 16'h0001);
    endtask
    task automatic write_page(input seewr_row_type r, input logic [7:0] first);
        logic [13:0] a;
        a = r.addr[13:0];
        address(r.dev, r.addr);
        for (int k = 0; k < int'(r.count); k++) begin
            i_mst.send(first + 8'(k), ack);
            check(16'(ack), 16'(r.data_ack));
            if (r.data_ack) exp_mem[{a[13:6], 6'(a[5:0] + 6'(k))}] = first + 8'(k);
        end
        i_mst.stop();
    endtask
    task automatic read_at(input logic [7:0] dev, input logic [15:0] a, input int n);
        address(dev, a);
        i_mst.start();
        i_mst.send(dev | 8'h01, ack);
        check(16'(ack), 16'h0001);
        for (int k = 0; k < n; k++) begin
            i_mst.recv(k < n - 1, rd);
            check(16'(rd), 16'(exp_mem[14'(a[13:0] + 14'(k))]));
        end
        i_mst.stop();
    endtask
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        wp_in = 1'b0;
        pgm_ready = 1'b1;
        err_total = 0;
        comparisons = 0;
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
            exp_mem[i] = 8'(i) ^ 8'h5A;
        end
        repeat (20) @(negedge clk);
        check(16'({sda_oe, busy, pgm_valid}), 16'h0000);
        check(16'(mem_rd_addr), 16'h0000);
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        $display("Test reset done");
        foreach (rows[i]) begin
            @(negedge clk);
            wp_in = rows[i].wp;
            write_page(rows[i], 8'h30 + 8'(i * 16));
            if (rows[i].data_ack) check(16'(busy), 16'h0001);
            @(negedge clk);
            wait_idle();
            wp_in = 1'b0;
            read_at(rows[i].dev, rows[i].addr, int'(rows[i].count) + 1);
            $display("Test row %0d done", i);
        end
        i_mst.start();
        i_mst.send(8'hB0, ack);
        check(16'(ack), 16'h0000);
        i_mst.send(8'h00, ack);
        check(16'(ack), 16'h0000);
        i_mst.stop();
        $display("Test foreign address done");
        @(negedge clk);
        pgm_ready = 1'b0;
        write_page(seewr_row_type'{8'hA4, 16'h0BFE, 1'b0, 8'h42, 1'b1}, 8'h80);
        i_mst.start();
        i_mst.send(8'hA0, ack);
        check(16'(ack), 16'h0000);
        i_mst.stop();
        check(16'(pgm_valid), 16'h0001);
        @(negedge clk);
        pgm_ready = 1'b1;
        wait_idle();
        i_mst.start();
        i_mst.send(8'hA0, ack);
        check(16'(ack), 16'h0001);
        i_mst.stop();
        read_at(8'hA0, 16'h0BC0, 64);
        $display("Test page wrap done");
        i_mst.start();
        i_mst.send(8'hA1, ack);
        i_mst.recv(1'b0, rd);
        i_mst.recv(1'b0, rd);
        check(16'(rd), 16'h00FF);
        i_mst.stop();
        $display("Test read refusal done");
        close_out();
    end
    initial begin
        #450000;
        err_total++;
        $display("Watchdog expired at %0t", $time);
        close_out();
    end
endmodule // seewr_slave_test
bind seewr_slave seewr_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (.clk(clk),
    .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_in(wp_in), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .pgm_valid(pgm_valid), .pgm_ready(pgm_ready), .pgm_word(pgm_word), .busy(busy));
